/* logic/pvsg_core.v */
// programmable video sync generator core with byte load port
`timescale 1ns/1ps
`include "pvsg_defs.vh"

module pvsg_core #(
    parameter        AUTO_RUN    = 0,
    parameter [11:0] EQ_WIDTH    = 12'h020,
    parameter [11:0] SERR_WIDTH  = 12'h040,
    parameter [12:0] EQ_INT_STA  = 13'h0001,
    parameter [12:0] EQ_INT_END  = 13'h0013,
    parameter [11:0] LGATE_STA   = 12'h0C0,
    parameter [11:0] LGATE_END   = 12'h100,
    parameter [12:0] FGATE_STA   = 13'h0030,
    parameter [12:0] FGATE_END   = 13'h0040,
    parameter [12:0] FIRQ_STA    = 13'h0002,
    parameter [12:0] FIRQ_END    = 13'h0004
) (
    input  wire        clk_i,
    input  wire        reset_n_i,
    input  wire        async_clear_i,
    input  wire        pixel_clk_i,
    input  wire        load_i,
    input  wire        addr_data_i,
    input  wire        byte_half_select_i,
    input  wire [7:0]  data_i,
    output reg         vert_or_composite_blank_out_o,
    output reg         vert_or_composite_sync_out_o,
    output reg         horiz_blank_or_gate_out_o,
    output reg         horiz_sync_or_vertical_gating_pulse_out_o,
    output reg         odd_even_field_o
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers; first stage feeds only the second

reg        pix_s1_reg;
reg        pix_s2_reg;
reg        pix_s3_reg;
reg        load_s1_reg;
reg        load_s2_reg;
reg        load_s3_reg;
reg        ad_s1_reg;
reg        ad_s2_reg;
reg        bh_s1_reg;
reg        bh_s2_reg;
reg [7:0]  data_s1_reg;
reg [7:0]  data_s2_reg;
reg        clr_s1_reg;
reg        clr_s2_reg;

always @(posedge clk_i) begin
    pix_s1_reg  <= pixel_clk_i;
    pix_s2_reg  <= pix_s1_reg;
    pix_s3_reg  <= pix_s2_reg;
    load_s1_reg <= load_i;
    load_s2_reg <= load_s1_reg;
    load_s3_reg <= load_s2_reg;
    ad_s1_reg   <= addr_data_i;
    ad_s2_reg   <= ad_s1_reg;
    bh_s1_reg   <= byte_half_select_i;
    bh_s2_reg   <= bh_s1_reg;
    data_s1_reg <= data_i;
    data_s2_reg <= data_s1_reg;
end

// clear releases through two flops so the core leaves reset on a clean edge
always @(posedge clk_i or posedge async_clear_i) begin
    if (async_clear_i) begin
        clr_s1_reg <= 1'b1;
        clr_s2_reg <= 1'b1;
    end else begin
        clr_s1_reg <= 1'b0;
        clr_s2_reg <= clr_s1_reg;
    end
end

wire pix_fall  = pix_s3_reg & ~pix_s2_reg;
wire load_fall = load_s3_reg & ~load_s2_reg;
wire load_rise = ~load_s3_reg & load_s2_reg;
wire clr_hold  = clr_s2_reg | ~reset_n_i;

////////////////////////////////////////////////////////////////////////////////
// load port and register file

localparam [11:0] MODE_RST = (AUTO_RUN != 0) ? `PVSG_MODE_RST_AUTORUN
                                             : `PVSG_MODE_RST_BASE;

reg [11:0] regs_reg [0:8];
reg [4:0]  addr_reg;
reg        auto_reg;
reg        ad_lat_reg;
reg        bh_lat_reg;

// the whole register file lives on clk_i, fed by synchronised pins
always @(posedge clk_i or posedge async_clear_i) begin
    if (async_clear_i) begin
        regs_reg[0] <= MODE_RST;
        regs_reg[1] <= `PVSG_H_FP_RST;
        regs_reg[2] <= `PVSG_H_SYNC_END_RST;
        regs_reg[3] <= `PVSG_H_BLANK_RST;
        regs_reg[4] <= `PVSG_CLOCKS_LINE_RST;
        regs_reg[5] <= `PVSG_V_FP_RST;
        regs_reg[6] <= `PVSG_V_SYNC_END_RST;
        regs_reg[7] <= `PVSG_V_BLANK_RST;
        regs_reg[8] <= `PVSG_LINES_FRAME_RST;
        addr_reg    <= 5'h00;
        auto_reg    <= 1'b0;
        ad_lat_reg  <= 1'b0;
        bh_lat_reg  <= 1'b0;
    end else if (clr_hold) begin
        regs_reg[0] <= MODE_RST;
        regs_reg[1] <= `PVSG_H_FP_RST;
        regs_reg[2] <= `PVSG_H_SYNC_END_RST;
        regs_reg[3] <= `PVSG_H_BLANK_RST;
        regs_reg[4] <= `PVSG_CLOCKS_LINE_RST;
        regs_reg[5] <= `PVSG_V_FP_RST;
        regs_reg[6] <= `PVSG_V_SYNC_END_RST;
        regs_reg[7] <= `PVSG_V_BLANK_RST;
        regs_reg[8] <= `PVSG_LINES_FRAME_RST;
        addr_reg    <= 5'h00;
        auto_reg    <= 1'b0;
        ad_lat_reg  <= 1'b0;
        bh_lat_reg  <= 1'b0;
    end else begin
        if (load_fall) begin
            ad_lat_reg <= ad_s2_reg;
            bh_lat_reg <= bh_s2_reg;
        end
        if (load_rise) begin
            if (!ad_lat_reg) begin
                addr_reg <= data_s2_reg[4:0];
                auto_reg <= bh_lat_reg;
            end else begin
                // a half write keeps the other half; upper byte carries four bits only
                case (addr_reg)
                    `PVSG_REG_MODE: begin
                        if (bh_lat_reg)
                            regs_reg[0] <= {data_s2_reg[3:0], regs_reg[0][7:0]};
                        else
                            regs_reg[0] <= {regs_reg[0][11:8], data_s2_reg};
                    end
                    `PVSG_REG_H_FRONT_PORCH: begin
                        if (bh_lat_reg)
                            regs_reg[1] <= {data_s2_reg[3:0], regs_reg[1][7:0]};
                        else
                            regs_reg[1] <= {regs_reg[1][11:8], data_s2_reg};
                    end
                    `PVSG_REG_H_SYNC_END: begin
                        if (bh_lat_reg)
                            regs_reg[2] <= {data_s2_reg[3:0], regs_reg[2][7:0]};
                        else
                            regs_reg[2] <= {regs_reg[2][11:8], data_s2_reg};
                    end
                    `PVSG_REG_H_BLANK_WIDTH: begin
                        if (bh_lat_reg)
                            regs_reg[3] <= {data_s2_reg[3:0], regs_reg[3][7:0]};
                        else
                            regs_reg[3] <= {regs_reg[3][11:8], data_s2_reg};
                    end
                    `PVSG_REG_CLOCKS_LINE: begin
                        if (bh_lat_reg)
                            regs_reg[4] <= {data_s2_reg[3:0], regs_reg[4][7:0]};
                        else
                            regs_reg[4] <= {regs_reg[4][11:8], data_s2_reg};
                    end
                    `PVSG_REG_V_FRONT_PORCH: begin
                        if (bh_lat_reg)
                            regs_reg[5] <= {data_s2_reg[3:0], regs_reg[5][7:0]};
                        else
                            regs_reg[5] <= {regs_reg[5][11:8], data_s2_reg};
                    end
                    `PVSG_REG_V_SYNC_END: begin
                        if (bh_lat_reg)
                            regs_reg[6] <= {data_s2_reg[3:0], regs_reg[6][7:0]};
                        else
                            regs_reg[6] <= {regs_reg[6][11:8], data_s2_reg};
                    end
                    `PVSG_REG_V_BLANK_WIDTH: begin
                        if (bh_lat_reg)
                            regs_reg[7] <= {data_s2_reg[3:0], regs_reg[7][7:0]};
                        else
                            regs_reg[7] <= {regs_reg[7][11:8], data_s2_reg};
                    end
                    `PVSG_REG_LINES_FRAME: begin
                        if (bh_lat_reg)
                            regs_reg[8] <= {data_s2_reg[3:0], regs_reg[8][7:0]};
                        else
                            regs_reg[8] <= {regs_reg[8][11:8], data_s2_reg};
                    end
                    default: begin
                        // past the last register: byte dropped, auto-load still steps
                    end
                endcase
                if (bh_lat_reg && auto_reg)
                    addr_reg <= addr_reg + 5'h01;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// decoded mode fields and timing registers

wire [11:0] mode      = regs_reg[0];
wire [11:0] h_fp      = regs_reg[1];
wire [11:0] h_sync_e  = regs_reg[2];
wire [11:0] h_blank_w = regs_reg[3];
wire [11:0] h_max     = regs_reg[4];
wire [12:0] v_fp      = {1'b0, regs_reg[5]};
wire [12:0] v_sync_e  = {1'b0, regs_reg[6]};
wire [12:0] v_blank_w = {1'b0, regs_reg[7]};
wire [12:0] v_frame   = {1'b0, regs_reg[8]};

wire [1:0] scan      = mode[`PVSG_B_SCAN_HI:`PVSG_B_SCAN_LO];
// illegal scan code is run as non-interlaced single: host must not write it
wire interlace = (scan == `PVSG_SCAN_INTERLACED);
wire dbl_mode  = (scan == `PVSG_SCAN_INTERLACED) || (scan == `PVSG_SCAN_NI_DOUBLE);
wire eq_en     = ~mode[`PVSG_B_EQ_DISABLE];
// counter test mode has no factory scan path here; only run enable matters
wire run       = mode[`PVSG_B_CLK_ENABLE];
wire step      = pix_fall & run;

////////////////////////////////////////////////////////////////////////////////
// horizontal and vertical counters

reg [11:0] hcnt_reg;
reg [12:0] vcnt_reg;
reg        vertical_blank_reg;
reg        vsync_reg;
reg        fgate_reg;
reg        firq_reg;

wire [11:0] half    = {1'b0, h_max[11:1]};
wire [12:0] v_max   = interlace ? {v_frame[11:0], 1'b0} : v_frame;
wire [11:0] hcnt_n  = (hcnt_reg >= h_max) ? 12'h001 : hcnt_reg + 12'h001;
wire        line_st = (hcnt_n == 12'h001);
wire        mid_st  = interlace && (hcnt_n == half + 12'h001);
wire [12:0] vcnt_n  = (line_st || mid_st) ?
                      ((vcnt_reg >= v_max) ? 13'h0001 : vcnt_reg + 13'h0001) :
                      vcnt_reg;

// hsync leading edges; interlace adds one half a line later
wire hs_edge = (hcnt_n == h_fp) || (interlace && (hcnt_n == h_fp + half));

wire horizontal_blank_n = (hcnt_n < h_blank_w);
wire hsync_n  = (hcnt_n >= h_fp) && (hcnt_n < h_sync_e);
wire lgate_n  = (hcnt_n >= LGATE_STA) && (hcnt_n < LGATE_END);

wire vertical_blank_n = line_st ? (vcnt_n < v_blank_w) : vertical_blank_reg;
wire vsync_n  = hs_edge ? ((vcnt_n >= v_fp) && (vcnt_n < v_sync_e))
                        : vsync_reg;
wire fgate_n  = line_st ? ((vcnt_n >= FGATE_STA) && (vcnt_n < FGATE_END)) : fgate_reg;
wire firq_n   = line_st ? ((vcnt_n >= FIRQ_STA) && (vcnt_n < FIRQ_END)) : firq_reg;

always @(posedge clk_i or posedge async_clear_i) begin
    if (async_clear_i) begin
        hcnt_reg   <= 12'h000;
        vcnt_reg   <= 13'h0000;
        vertical_blank_reg <= 1'b0;
        vsync_reg  <= 1'b0;
        fgate_reg  <= 1'b0;
        firq_reg   <= 1'b0;
    end else if (clr_hold) begin
        hcnt_reg   <= 12'h000;
        vcnt_reg   <= 13'h0000;
        vertical_blank_reg <= 1'b0;
        vsync_reg  <= 1'b0;
        fgate_reg  <= 1'b0;
        firq_reg   <= 1'b0;
    end else if (step) begin
        hcnt_reg   <= hcnt_n;
        vcnt_reg   <= vcnt_n;
        vertical_blank_reg <= vertical_blank_n;
        vsync_reg  <= vsync_n;
        fgate_reg  <= fgate_n;
        firq_reg   <= firq_n;
    end
end

////////////////////////////////////////////////////////////////////////////////
// equalization and serration shaping

// position within the pulse period: half a line in double modes
wire [11:0] hpos    = (dbl_mode && (hcnt_n > half)) ? hcnt_n - half : hcnt_n;
wire [11:0] per     = dbl_mode ? half : h_max;
wire        eq_n    = (hpos >= h_fp) && (hpos < h_fp + EQ_WIDTH);
// serration: sync held low except a short gap at the end of each period
wire        serr_n  = (hpos >= h_fp) && (hpos < h_fp + per - SERR_WIDTH);
// interval counted in half-lines from frame start when interlaced, so it comes once per frame
wire        eq_int  = eq_en && vertical_blank_n &&
                      (vcnt_n >= EQ_INT_STA) && (vcnt_n < EQ_INT_END);

wire composite_sync_n  = eq_int ? (vsync_n ? serr_n : eq_n)
                       : (hsync_n | vsync_n);
wire composite_blank_n = horizontal_blank_n | vertical_blank_n;
wire cursor_n = lgate_n & fgate_n;

////////////////////////////////////////////////////////////////////////////////
// output selection and polarity

reg sel_blank;
reg sel_sync;
reg sel_third;
reg sel_fourth;

always @* begin
    sel_blank  = mode[`PVSG_B_SEP_BLANK] ? vertical_blank_n : composite_blank_n;
    sel_sync   = mode[`PVSG_B_SEP_SYNC]  ? vsync_n  : composite_sync_n;
    if (mode[`PVSG_B_SEP_BLANK])
        sel_third = horizontal_blank_n;
    else
        sel_third = mode[`PVSG_B_CURSOR_SEL] ? cursor_n : lgate_n;
    if (mode[`PVSG_B_SEP_SYNC])
        sel_fourth = hsync_n;
    else
        sel_fourth = mode[`PVSG_B_CURSOR_SEL] ? firq_n : fgate_n;
end

// polarity bit 0 inverts the active-high internal pulse
always @(posedge clk_i or posedge async_clear_i) begin
    if (async_clear_i) begin
        vert_or_composite_blank_out_o <= 1'b1;
        vert_or_composite_sync_out_o  <= 1'b1;
        horiz_blank_or_gate_out_o     <= 1'b1;
        horiz_sync_or_vertical_gating_pulse_out_o     <= 1'b1;
        odd_even_field_o              <= 1'b1;
    end else if (clr_hold) begin
        vert_or_composite_blank_out_o <= ~mode[`PVSG_B_POL_BLANK];
        vert_or_composite_sync_out_o  <= ~mode[`PVSG_B_POL_SYNC];
        horiz_blank_or_gate_out_o     <= ~mode[`PVSG_B_POL_THIRD];
        horiz_sync_or_vertical_gating_pulse_out_o     <= ~mode[`PVSG_B_POL_FOURTH];
        odd_even_field_o              <= 1'b1;
    end else if (step) begin
        vert_or_composite_blank_out_o <= sel_blank  ~^ mode[`PVSG_B_POL_BLANK];
        vert_or_composite_sync_out_o  <= sel_sync   ~^ mode[`PVSG_B_POL_SYNC];
        horiz_blank_or_gate_out_o     <= sel_third  ~^ mode[`PVSG_B_POL_THIRD];
        horiz_sync_or_vertical_gating_pulse_out_o     <= sel_fourth ~^ mode[`PVSG_B_POL_FOURTH];
        odd_even_field_o              <= ~interlace || (vcnt_n <= v_frame);
    end else if (!interlace) begin
        odd_even_field_o              <= 1'b1;
    end
end

endmodule // pvsg_core

/* logic/pvsg_defs.vh */
// constants for the programmable video sync generator
`ifndef PVSG_DEFS_VH
`define PVSG_DEFS_VH

// register indices on the byte load port
`define PVSG_REG_MODE          5'h00
`define PVSG_REG_H_FRONT_PORCH 5'h01
`define PVSG_REG_H_SYNC_END    5'h02
`define PVSG_REG_H_BLANK_WIDTH 5'h03
`define PVSG_REG_CLOCKS_LINE   5'h04
`define PVSG_REG_V_FRONT_PORCH 5'h05
`define PVSG_REG_V_SYNC_END    5'h06
`define PVSG_REG_V_BLANK_WIDTH 5'h07
`define PVSG_REG_LINES_FRAME   5'h08
`define PVSG_REG_LAST          5'h08

// mode_and_output_control fields
`define PVSG_B_SEP_BLANK   0
`define PVSG_B_SEP_SYNC    1
`define PVSG_B_CURSOR_SEL  2
`define PVSG_B_SCAN_LO     3
`define PVSG_B_SCAN_HI     4
`define PVSG_B_POL_BLANK   5
`define PVSG_B_POL_SYNC    6
`define PVSG_B_POL_THIRD   7
`define PVSG_B_POL_FOURTH  8
`define PVSG_B_EQ_DISABLE  9
`define PVSG_B_CLK_ENABLE  10
`define PVSG_B_COUNT_TEST  11

// scan modes in bits 4:3
`define PVSG_SCAN_INTERLACED 2'h0
`define PVSG_SCAN_NI_DOUBLE  2'h1
`define PVSG_SCAN_ILLEGAL    2'h2
`define PVSG_SCAN_NI_SINGLE  2'h3

// register defaults after clear
`define PVSG_MODE_RST_BASE    12'h000
`define PVSG_MODE_RST_AUTORUN 12'h400
`define PVSG_H_FP_RST         12'h010
`define PVSG_H_SYNC_END_RST   12'h050
`define PVSG_H_BLANK_RST      12'h0A0
`define PVSG_CLOCKS_LINE_RST  12'h320
`define PVSG_V_FP_RST         12'h007
`define PVSG_V_SYNC_END_RST   12'h00D
`define PVSG_V_BLANK_RST      12'h029
`define PVSG_LINES_FRAME_RST  12'h20D

`endif

/* verif/pvsg_core_properties.sv */
// assertion checker for the sync generator output ports
`timescale 1ns/1ps
module pvsg_props #(
    parameter AUTO_RUN = 0
) (
    input wire       clk_i,
    input wire       reset_n_i,
    input wire       async_clear_i,
    input wire       pixel_clk_i,
    input wire       load_i,
    input wire       addr_data_i,
    input wire       byte_half_select_i,
    input wire [7:0] data_i,
    input wire       vert_or_composite_blank_out_o,
    input wire       vert_or_composite_sync_out_o,
    input wire       horiz_blank_or_gate_out_o,
    input wire       horiz_sync_or_vertical_gating_pulse_out_o,
    input wire       odd_even_field_o
);
    wire [3:0] outs = {vert_or_composite_blank_out_o, vert_or_composite_sync_out_o,
                       horiz_blank_or_gate_out_o, horiz_sync_or_vertical_gating_pulse_out_o};
    reg  [2:0] since_fall_reg;
    reg        pix_reg;
    reg        idle_reg;
    // cycles since the pixel pin was last seen falling, saturating
    always @(posedge clk_i) begin
        pix_reg <= pixel_clk_i;
        if (pix_reg && !pixel_clk_i) since_fall_reg <= 3'h0;
        else if (since_fall_reg != 3'h7) since_fall_reg <= since_fall_reg + 3'h1;
        if (async_clear_i || !reset_n_i) idle_reg <= 1'b1;
        else if (!load_i) idle_reg <= 1'b0;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i || async_clear_i);
    property p_clear_outs;
        disable iff (!reset_n_i) async_clear_i |-> outs == 4'hF;
    endproperty
    a_clear_outs: assert property (p_clear_outs) else $error("outputs active in clear");
    property p_clear_field;
        disable iff (!reset_n_i) async_clear_i |-> odd_even_field_o;
    endproperty
    a_clear_field: assert property (p_clear_field) else $error("field low in clear");
    property p_clear_release;
        disable iff (!reset_n_i) $fell(async_clear_i) |-> (outs == 4'hF) [*3];
    endproperty
    a_clear_release: assert property (p_clear_release) else $error("early output");
    property p_reset_outs;
        disable iff (async_clear_i)
            !reset_n_i ##1 !reset_n_i |=> outs == 4'hF && odd_even_field_o;
    endproperty
    a_reset_outs: assert property (p_reset_outs) else $error("reset levels wrong");
    property p_idle_frozen;
        idle_reg && AUTO_RUN == 0 |-> outs == 4'hF && odd_even_field_o;
    endproperty
    a_idle_frozen: assert property (p_idle_frozen) else $error("ran while disabled");
    property p_out_step;
        $past(reset_n_i) && !$past(async_clear_i) && outs != $past(outs)
            |-> since_fall_reg <= 3'h4;
    endproperty
    a_out_step: assert property (p_out_step) else $error("output moved off step");
    property p_field_step;
        $past(reset_n_i) && !$past(async_clear_i) && $changed(odd_even_field_o)
            |-> since_fall_reg <= 3'h4;
    endproperty
    a_field_step: assert property (p_field_step) else $error("field moved off step");
    property p_step_spacing;
        $past(reset_n_i) && $changed(outs) |=> $stable(outs) [*3];
    endproperty
    a_step_spacing: assert property (p_step_spacing) else $error("steps too close");
endmodule // pvsg_props
bind pvsg_core pvsg_props #(.AUTO_RUN(AUTO_RUN)) u_pvsg_props (.*);

/* verif/pvsg_core_tb_top.sv */
// testbench for the sync generator core
`timescale 1ns/1ps
module pvsg_core_tb_top;
    reg         clk_i;
    reg         reset_n_i;
    reg         pixel_clk_i;
    wire        load_i;
    wire        addr_data_i;
    wire        byte_half_select_i;
    wire        async_clear_i;
    wire [7:0]  data_i;
    wire [4:0]  outs;
    integer     miscompares;
    integer     checked;
    integer     cycles;
    integer     i;
    reg  [11:0] timing [1:8];
    reg  [52:0] rows [0:4];
    pvsg_host u_pvsg_host (.clk_i(clk_i), .load_o(load_i), .addr_data_o(addr_data_i),
        .byte_half_select_o(byte_half_select_i), .data_o(data_i),
        .async_clear_o(async_clear_i));
    pvsg_core u_pvsg_core (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .async_clear_i(async_clear_i), .pixel_clk_i(pixel_clk_i), .load_i(load_i),
        .addr_data_i(addr_data_i), .byte_half_select_i(byte_half_select_i),
        .data_i(data_i), .vert_or_composite_blank_out_o(outs[4]),
        .vert_or_composite_sync_out_o(outs[3]), .horiz_blank_or_gate_out_o(outs[2]),
        .horiz_sync_or_vertical_gating_pulse_out_o(outs[1]), .odd_even_field_o(outs[0]));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // pixel clock free running, phase unrelated to clk_i
    initial begin
        pixel_clk_i = 1'b0;
        #7;
        forever #100 pixel_clk_i = ~pixel_clk_i;
    end
    task check(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
                miscompares = miscompares + 1;
            end
        end
    endtask
    task conclude;
        begin
            $display("miscompares %0d checked %0d", miscompares, checked);
            if (miscompares == 0 && checked > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    // low counts of the four outputs and high count of field over one frame
    task measure(input [52:0] row);
        integer nb, ns, nt, nf, nd;
        begin
            nb = 0; ns = 0; nt = 0; nf = 0; nd = 0;
            repeat (96) @(posedge pixel_clk_i);
            repeat (96) begin
                @(posedge pixel_clk_i);
                nb = nb + !outs[4];
                ns = ns + !outs[3];
                nt = nt + !outs[2];
                nf = nf + !outs[1];
                nd = nd + outs[0];
            end
            if (!row[52]) begin
                check(nb[7:0], row[39:32]);
                check(ns[7:0], row[31:24]);
                check(nt[7:0], row[23:16]);
                check(nf[7:0], row[15:8]);
            end
            check(nd[7:0], row[7:0]);
        end
    endtask
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            conclude;
        end
    end
    initial begin
        miscompares = 0;
        checked = 0;
        cycles = 0;
        reset_n_i = 1'b0;
        // front porch, sync end, blank width, clocks per line, then vertical set
        timing[1] = 12'h003; timing[2] = 12'h005; timing[3] = 12'h007; timing[4] = 12'h010;
        timing[5] = 12'h002; timing[6] = 12'h003; timing[7] = 12'h004; timing[8] = 12'h006;
        // skip, mode, blank, sync, third, fourth, field
        rows[0] = {1'b0, 12'h61B, 8'd48, 8'd16, 8'd36, 8'd12, 8'd96};
        rows[1] = {1'b0, 12'h7FB, 8'd48, 8'd80, 8'd60, 8'd84, 8'd96};
        rows[2] = {1'b0, 12'h618, 8'd66, 8'd26, 8'd0, 8'd0, 8'd96};
        rows[3] = {1'b0, 12'h61C, 8'd66, 8'd26, 8'd0, 8'd32, 8'd96};
        rows[4] = {1'b1, 12'h600, 8'd0, 8'd0, 8'd0, 8'd0, 8'd48};
        repeat (20) @(negedge clk_i);
        reset_n_i = 1'b1;
        u_pvsg_host.clear_pulse;
        check({3'h0, outs}, 8'h1F);
        repeat (200) @(negedge clk_i);
        check({3'h0, outs}, 8'h1F);
        u_pvsg_host.auto_load(8'h01);
        for (i = 1; i <= 8; i = i + 1) u_pvsg_host.put(timing[i]);
        for (i = 0; i < 5; i = i + 1) begin
            u_pvsg_host.write_mode(rows[i][51:40]);
            measure(rows[i]);
        end
        @(negedge clk_i);
        reset_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        check({3'h0, outs}, 8'h1F);
        reset_n_i = 1'b1;
        repeat (200) @(negedge clk_i);
        check({3'h0, outs}, 8'h1F);
        conclude;
    end
endmodule // pvsg_core_tb_top

/* verif/pvsg_host.sv */
// host model loading timing registers through the byte port
`timescale 1ns/1ps
module pvsg_host (
    input  wire       clk_i,
    output reg        load_o,
    output reg        addr_data_o,
    output reg        byte_half_select_o,
    output reg  [7:0] data_o,
    output reg        async_clear_o
);
    initial begin
        load_o = 1'b1;
        addr_data_o = 1'b1;
        byte_half_select_o = 1'b0;
        data_o = 8'h00;
        async_clear_o = 1'b0;
    end
    // four clk per phase keeps selects and data steady around both edges
    task cyc(input ad, input bh, input [7:0] b);
        begin
            @(negedge clk_i);
            addr_data_o = ad;
            byte_half_select_o = bh;
            data_o = b;
            repeat (4) @(negedge clk_i);
            load_o = 1'b0;
            repeat (4) @(negedge clk_i);
            load_o = 1'b1;
            repeat (4) @(negedge clk_i);
            data_o = ~b;
            addr_data_o = ~ad;
        end
    endtask
    task put(input [11:0] v);
        begin
            cyc(1'b1, 1'b0, v[7:0]);
            cyc(1'b1, 1'b1, {4'h0, v[11:8]});
        end
    endtask
    task write_reg(input [7:0] a, input [11:0] v);
        begin
            cyc(1'b0, 1'b0, a);
            put(v);
        end
    endtask
    task auto_load(input [7:0] a);
        cyc(1'b0, 1'b1, a);
    endtask
    // counter test bit always kept low; callers never pass scan code 10
    task write_mode(input [11:0] v);
        write_reg(8'h00, v & 12'h7FF);
    endtask
    task clear_pulse;
        begin
            @(negedge clk_i);
            async_clear_o = 1'b1;
            repeat (3) @(negedge clk_i);
            async_clear_o = 1'b0;
            repeat (4) @(negedge clk_i);
        end
    endtask
endmodule // pvsg_host
